//--- design/rec_gpio_pkg.sv
// Purpose: constants and types for the recording-profile output port
// Assumes: 40 MHz system clock
// Notes:   pulse width is counted in system clock cycles
package rec_gpio_pkg;

   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned PULSE_MS     = 100;
   localparam int unsigned PULSE_CYC    = CLK_HZ / 1000 * PULSE_MS;
   localparam int unsigned CNT_W        = 23;
   localparam int unsigned CHAN_W       = 16;
   localparam int unsigned LOCAL_W      = 8;
   localparam int unsigned LOCAL_SEL_W  = 3;
   localparam int unsigned NUM_IN       = 5;

   // port-source selector encoding
   typedef enum logic [1:0] {
      SRC_PROTOCOL = 2'h0,
      SRC_NETWORK  = 2'h1,
      SRC_LOCAL    = 2'h2,
      SRC_RSVD     = 2'h3
   } src_sel_t;

   // drivers of the five output pins
   typedef struct packed {
      logic active_lamp;
      logic idle_lamp;
      logic unused_out;
      logic begin_pulse;
      logic halt_pulse;
   } port_out_t;

   localparam port_out_t PORT_RESET = '{
      active_lamp: 1'b0,
      idle_lamp:   1'b1,
      unused_out:  1'b0,
      begin_pulse: 1'b0,
      halt_pulse:  1'b0
   };

endpackage : rec_gpio_pkg

//--- design/rec_gpio_port.sv
// Purpose: recording-device logic profile for one output port
// Assumes: all inputs synchronous to CLK_I; outputs active high
// Notes:   open-collector drive is outside this block
`timescale 1ns/1ps

module rec_gpio_port #(
   parameter int unsigned PULSE_CYC = rec_gpio_pkg::PULSE_CYC
) (
   // clock and reset
   input  wire logic                                 CLK_I,
   input  wire logic                                 RST_N_I,
   // source selection
   input  wire logic [1:0]                           SRC_SEL_I,
   input  wire logic [rec_gpio_pkg::CHAN_W-1:0]      CHAN_NUM_I,
   input  wire logic [rec_gpio_pkg::LOCAL_SEL_W-1:0] LOCAL_SEL_I,
   // protocol commands
   input  wire logic                                 PROTO_CMD_VALID_I,
   input  wire logic                                 PROTO_CMD_REC_I,
   // network channel state
   input  wire logic                                 NET_VALID_I,
   input  wire logic [rec_gpio_pkg::CHAN_W-1:0]      NET_CHAN_I,
   input  wire logic                                 NET_REC_I,
   // local inputs
   input  wire logic [rec_gpio_pkg::LOCAL_W-1:0]     LOCAL_REC_I,
   // port pins, active low, ignored
   input  wire logic [rec_gpio_pkg::NUM_IN-1:0]      PORT_IN_N_I,
   // port outputs
   output logic                                      ACTIVE_LAMP_O,
   output logic                                      IDLE_LAMP_O,
   output logic                                      UNUSED_OUT_O,
   output logic                                      BEGIN_PULSE_O,
   output logic                                      HALT_PULSE_O
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_BEGIN,
      ST_ACTIVE,
      ST_HALT
   } state_t;

   state_t                               state_r, state_nxt;
   logic [rec_gpio_pkg::CNT_W-1:0]       cnt_r, cnt_nxt;
   logic                                 want_r, want_nxt;
   rec_gpio_pkg::port_out_t              out_r, out_nxt;

   localparam logic [rec_gpio_pkg::CNT_W-1:0] CNT_LAST =
      rec_gpio_pkg::CNT_W'(PULSE_CYC - 1);

   // requested record mode from the chosen source
   always_comb begin
      want_nxt = want_r;
      unique case (rec_gpio_pkg::src_sel_t'(SRC_SEL_I))
         rec_gpio_pkg::SRC_PROTOCOL: begin
            if (PROTO_CMD_VALID_I) begin
               want_nxt = PROTO_CMD_REC_I;
            end
         end
         rec_gpio_pkg::SRC_NETWORK: begin
            if (NET_VALID_I && NET_CHAN_I == CHAN_NUM_I) begin
               want_nxt = NET_REC_I;
            end
         end
         rec_gpio_pkg::SRC_LOCAL: begin
            want_nxt = LOCAL_REC_I[LOCAL_SEL_I];
         end
         default: begin
            want_nxt = want_r;
         end
      endcase
   end

   // sequencer: pulse first, then lamps
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         ST_IDLE: begin
            if (want_r) begin
               state_nxt = ST_BEGIN;
               cnt_nxt   = '0;
            end
         end
         ST_BEGIN: begin
            if (cnt_r == CNT_LAST) begin
               state_nxt = ST_ACTIVE;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         ST_ACTIVE: begin
            if (!want_r) begin
               state_nxt = ST_HALT;
               cnt_nxt   = '0;
            end
         end
         ST_HALT: begin
            if (cnt_r == CNT_LAST) begin
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // registered pin drivers
   always_comb begin
      out_nxt             = rec_gpio_pkg::PORT_RESET;
      out_nxt.unused_out  = 1'b0;
      out_nxt.begin_pulse = (state_nxt == ST_BEGIN);
      out_nxt.halt_pulse  = (state_nxt == ST_HALT);
      out_nxt.active_lamp = (state_nxt == ST_ACTIVE) ||
                            (state_nxt == ST_HALT);
      out_nxt.idle_lamp   = !out_nxt.active_lamp;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
         want_r  <= 1'b0;
         out_r   <= rec_gpio_pkg::PORT_RESET;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         want_r  <= want_nxt;
         out_r   <= out_nxt;
      end
   end

   assign ACTIVE_LAMP_O = out_r.active_lamp;
   assign IDLE_LAMP_O   = out_r.idle_lamp;
   assign UNUSED_OUT_O  = out_r.unused_out;
   assign BEGIN_PULSE_O = out_r.begin_pulse;
   assign HALT_PULSE_O  = out_r.halt_pulse;

   // checks
   property p_lamp_excl;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !(ACTIVE_LAMP_O && IDLE_LAMP_O);
   endproperty
   a_lamp_excl: assert property (p_lamp_excl)
      else $error("both lamps lit");

   property p_active_src;
      @(posedge CLK_I) disable iff (!RST_N_I)
      $rose(ACTIVE_LAMP_O) |-> $past(BEGIN_PULSE_O);
   endproperty
   a_active_src: assert property (p_active_src)
      else $error("active lamp rose without begin pulse");

   property p_idle_src;
      @(posedge CLK_I) disable iff (!RST_N_I)
      $rose(IDLE_LAMP_O) |-> $past(HALT_PULSE_O);
   endproperty
   a_idle_src: assert property (p_idle_src)
      else $error("idle lamp returned without halt pulse");

   property p_begin_start;
      @(posedge CLK_I) disable iff (!RST_N_I)
      $rose(BEGIN_PULSE_O) |-> $past(IDLE_LAMP_O) && $past(want_r);
   endproperty
   a_begin_start: assert property (p_begin_start)
      else $error("begin pulse without engage from idle");

   property p_halt_start;
      @(posedge CLK_I) disable iff (!RST_N_I)
      $rose(HALT_PULSE_O) |-> $past(ACTIVE_LAMP_O) && !$past(want_r);
   endproperty
   a_halt_start: assert property (p_halt_start)
      else $error("halt pulse without disengage");

   property p_pulse_len;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (BEGIN_PULSE_O || HALT_PULSE_O) |-> cnt_r <= CNT_LAST;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("pulse counter overran");

   property p_active_want;
      @(posedge CLK_I) disable iff (!RST_N_I)
      ACTIVE_LAMP_O && !HALT_PULSE_O && $stable(ACTIVE_LAMP_O)
         |-> $past(want_r);
   endproperty
   a_active_want: assert property (p_active_want)
      else $error("active lamp held without record mode");

   property p_unused;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !UNUSED_OUT_O;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused output driven");

   property p_proto_hold;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (SRC_SEL_I == rec_gpio_pkg::SRC_PROTOCOL && !PROTO_CMD_VALID_I)
         |=> $stable(want_r);
   endproperty
   a_proto_hold: assert property (p_proto_hold)
      else $error("record mode changed without protocol command");

   property p_lamp_cpl;
      @(posedge CLK_I) disable iff (!RST_N_I)
      IDLE_LAMP_O != ACTIVE_LAMP_O;
   endproperty
   a_lamp_cpl: assert property (p_lamp_cpl)
      else $error("idle lamp not complement of active lamp");

   property p_begin_dark;
      @(posedge CLK_I) disable iff (!RST_N_I)
      BEGIN_PULSE_O |-> !ACTIVE_LAMP_O && IDLE_LAMP_O;
   endproperty
   a_begin_dark: assert property (p_begin_dark)
      else $error("active lamp lit during begin pulse");

   property p_halt_lit;
      @(posedge CLK_I) disable iff (!RST_N_I)
      HALT_PULSE_O |-> ACTIVE_LAMP_O && !IDLE_LAMP_O;
   endproperty
   a_halt_lit: assert property (p_halt_lit)
      else $error("idle lamp lit during halt pulse");

endmodule : rec_gpio_port

//--- dv/rec_device_model.sv
// Purpose: far-side recording device sensing the port outputs
// Assumes: outputs active high, sampled on the system clock
// Notes:   reports each finished pulse with its kind and width
`timescale 1ns/1ps
module rec_device_model (
   // clock
   input  wire logic        clk_i,
   // sensed trigger pulses
   input  wire logic        begin_i,
   input  wire logic        halt_i,
   // pulse report
   output logic             done_o,
   output logic [1:0]       kind_o,
   output logic [31:0]      width_o
);
   logic [31:0] cnt_r  = '0;
   logic [1:0]  prev_r = '0;
   initial done_o = 1'h0;
   always_ff @(posedge clk_i) begin
      done_o <= 1'h0;
      prev_r <= {begin_i, halt_i};
      if (begin_i | halt_i) begin
         cnt_r <= cnt_r + 1;
      end else if (prev_r != 2'h0) begin
         done_o  <= 1'h1;
         kind_o  <= prev_r;
         width_o <= cnt_r;
         cnt_r   <= '0;
      end
   end
endmodule : rec_device_model

//--- dv/rec_gpio_port_tb_top.sv
// Purpose: self-checking bench for the recording-profile port
// Assumes: short pulse parameter in simulation
// Notes:   expected pulse kinds are queued by the driver
`timescale 1ns/1ps
module rec_gpio_port_tb_top;
   localparam int PW = 8;
   logic CLK_I, RST_N_I, PROTO_CMD_VALID_I, PROTO_CMD_REC_I;
   logic NET_VALID_I, NET_REC_I;
   logic [1:0] SRC_SEL_I;
   logic [15:0] CHAN_NUM_I, NET_CHAN_I;
   logic [2:0] LOCAL_SEL_I;
   logic [7:0] LOCAL_REC_I;
   logic [4:0] PORT_IN_N_I;
   logic ACTIVE_LAMP_O, IDLE_LAMP_O, UNUSED_OUT_O, BEGIN_PULSE_O, HALT_PULSE_O;
   logic done, ek;
   logic [1:0] kind, q[$];
   logic [31:0] width;
   int n_fail = 0, num_checks = 0;
   rec_gpio_port #(
      .PULSE_CYC         (PW)
   ) dut_u (
      .CLK_I             (CLK_I),
      .RST_N_I           (RST_N_I),
      .SRC_SEL_I         (SRC_SEL_I),
      .CHAN_NUM_I        (CHAN_NUM_I),
      .LOCAL_SEL_I       (LOCAL_SEL_I),
      .PROTO_CMD_VALID_I (PROTO_CMD_VALID_I),
      .PROTO_CMD_REC_I   (PROTO_CMD_REC_I),
      .NET_VALID_I       (NET_VALID_I),
      .NET_CHAN_I        (NET_CHAN_I),
      .NET_REC_I         (NET_REC_I),
      .LOCAL_REC_I       (LOCAL_REC_I),
      .PORT_IN_N_I       (PORT_IN_N_I),
      .ACTIVE_LAMP_O     (ACTIVE_LAMP_O),
      .IDLE_LAMP_O       (IDLE_LAMP_O),
      .UNUSED_OUT_O      (UNUSED_OUT_O),
      .BEGIN_PULSE_O     (BEGIN_PULSE_O),
      .HALT_PULSE_O      (HALT_PULSE_O)
   );
   rec_device_model peer_u (.clk_i(CLK_I), .begin_i(BEGIN_PULSE_O),
      .halt_i(HALT_PULSE_O), .done_o(done), .kind_o(kind), .width_o(width));
   initial begin
      CLK_I = 1'b0;
      forever #12.5 CLK_I = ~CLK_I;
   end
   task check_bits(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_bits
   task check_evt(input logic [1:0] got, input logic [1:0] exp);
      check_bits(32'(got), 32'(exp));
   endtask : check_evt
   task tally_and_finish;
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task cyc(input int n);
      repeat (n) begin
         @(posedge CLK_I);
         #2;
         PORT_IN_N_I = 5'($urandom);
      end
   endtask : cyc
   task cmd(input logic rec);
      PROTO_CMD_REC_I = rec;
      PROTO_CMD_VALID_I = 1;
      cyc(1);
      PROTO_CMD_VALID_I = 0;
      cyc(PW + 4);
   endtask : cmd
   task net(input logic [15:0] ch, input logic rec);
      NET_CHAN_I = ch;
      NET_REC_I = rec;
      NET_VALID_I = 1;
      cyc(1);
      NET_VALID_I = 0;
      cyc(PW + 4);
   endtask : net
   always @(posedge CLK_I) begin
      #1;
      if (RST_N_I === 1'b1) begin
         check_bits(32'(IDLE_LAMP_O ^ ACTIVE_LAMP_O), 32'h1);
         check_bits(32'(UNUSED_OUT_O), 32'h0);
      end
      if (BEGIN_PULSE_O === 1'h1) check_bits(32'(ACTIVE_LAMP_O), 0);
      if (HALT_PULSE_O === 1'h1) check_bits(32'(IDLE_LAMP_O), 0);
      if (done === 1'h1) begin
         ek = q.size() > 0;
         check_evt(kind, ek ? q.pop_front() : 2'h0);
         check_bits(width, PW);
         check_bits({ACTIVE_LAMP_O, IDLE_LAMP_O, UNUSED_OUT_O},
                    {kind, 1'h0});
      end
   end
   initial begin
      #(25 * 3000);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(41));
      RST_N_I = 1'b0;
      PROTO_CMD_VALID_I = 1'b0;
      PROTO_CMD_REC_I = 1'b0;
      NET_VALID_I = 1'b0;
      NET_REC_I = 1'b0;
      SRC_SEL_I = 2'h0;
      CHAN_NUM_I = 16'h0000;
      NET_CHAN_I = 16'h0000;
      LOCAL_SEL_I = 3'h0;
      LOCAL_REC_I = 8'h00;
      PORT_IN_N_I = 5'h00;
      cyc(8);
      RST_N_I = 1;
      check_bits({IDLE_LAMP_O, ACTIVE_LAMP_O, BEGIN_PULSE_O, HALT_PULSE_O},
                 4'h8);
      PROTO_CMD_REC_I = 1;
      LOCAL_REC_I = 8'hff;
      net(CHAN_NUM_I, 1);
      LOCAL_REC_I = 0;
      q.push_back(2'h2);
      cmd(1);
      q.push_back(2'h1);
      cmd(0);
      SRC_SEL_I = 1;
      CHAN_NUM_I = 16'($urandom);
      net(CHAN_NUM_I + 1, 1);
      q.push_back(2'h2);
      net(CHAN_NUM_I, 1);
      q.push_back(2'h1);
      net(CHAN_NUM_I, 0);
      SRC_SEL_I = 2;
      repeat (3) begin
         LOCAL_SEL_I = 3'($urandom);
         q.push_back(2'h2);
         LOCAL_REC_I = 8'(1 << LOCAL_SEL_I);
         cyc(PW + 4);
         q.push_back(2'h1);
         LOCAL_REC_I = ~8'(1 << LOCAL_SEL_I);
         cyc(PW + 4);
      end
      SRC_SEL_I = 2'h3;
      LOCAL_REC_I = 8'hff;
      net(CHAN_NUM_I, 1);
      cmd(1);
      SRC_SEL_I = 2'h2;
      q.push_back(2'h2);
      cyc(PW + 4);
      RST_N_I = 1'b0;
      LOCAL_REC_I = 8'h00;
      cyc(2);
      check_bits({IDLE_LAMP_O, ACTIVE_LAMP_O, BEGIN_PULSE_O, HALT_PULSE_O},
                 4'h8);
      RST_N_I = 1'b1;
      cyc(PW + 4);
      check_bits(q.size(), 0);
      tally_and_finish;
   end
endmodule : rec_gpio_port_tb_top
